// *** design/som_pkg.sv ***
/*
  Constants shared by the sum-of-products output slice: register map,
  field positions, reset values, product-term budgets and bus codes.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package som_pkg;
  // Slice geometry defaults
  localparam int SOM_NUM_IN = 4; // Dedicated input pins
  localparam int SOM_NUM_CELL = 4; // Output logic cells
  localparam int SOM_PT_PER_CELL = 8; // Product terms wired to one cell
  localparam int SOM_ADDR_W = 8; // Byte address width
  // Product terms used per structure
  localparam int SOM_PT_COMB = 6; // Dedicated combinatorial sum
  localparam int SOM_PT_IO = 7; // Bidirectional sum
  localparam int SOM_PT_REG = 8; // Registered sum
  // Register byte offsets
  localparam logic [7:0] SOM_OFS_CTRL = 8'h00; // Global control
  localparam logic [7:0] SOM_OFS_CELLCFG = 8'h04; // Per-cell mode and polarity
  localparam logic [7:0] SOM_OFS_STATUS = 8'h08; // Live pin and register view
  localparam logic [7:0] SOM_OFS_PT_BASE = 8'h40; // First product-term mask
  // Control register fields
  localparam int SOM_CTRL_SYNC_BIT = 0; // combinatorial_mode_select
  localparam int SOM_CTRL_ARCH_BIT = 1; // global_arch_control
  // Cell config fields: mode at 2*k, polarity at POL_LSB+k
  localparam int SOM_CFG_POL_LSB = 16; // First polarity bit
  // Status fields: byte lanes
  localparam int SOM_ST_PIN_LSB = 0; // Driven pin values
  localparam int SOM_ST_Q_LSB = 8; // Flip-flop states
  localparam int SOM_ST_OE_LSB = 16; // Drivers enabled
  localparam int SOM_ST_IN_LSB = 24; // Sampled cell pins
  // Reset values
  localparam logic SOM_RST_SYNC = 1'b0; // Registered structures allowed
  localparam logic SOM_RST_ARCH = 1'b1; // Term-controlled enables on
  localparam logic SOM_RST_POL = 1'b0; // No polarity flip
  // AXI responses
  localparam logic [1:0] SOM_RESP_OKAY = 2'b00; // Access done
  localparam logic [1:0] SOM_RESP_SLVERR = 2'b10; // Unmapped address
  // Cell operating modes, Gray ordered
  typedef enum logic [1:0] {
    SOM_MODE_COMB = 2'b00, // Always driven combinatorial
    SOM_MODE_IO = 2'b01, // Term-enabled bidirectional
    SOM_MODE_REG = 2'b11, // D flip-flop with feedback
    SOM_MODE_INPUT = 2'b10 // Driver off, pin is an input
  } som_mode_t;
  localparam som_mode_t SOM_RST_MODE = SOM_MODE_INPUT; // Pins float at reset
endpackage

// *** design/som_sop_slice.sv ***
/*
  Sum-of-products logic slice: input buffers, programmable AND plane,
  fixed OR per cell, and identical output logic cells with polarity XOR.
  Assumes all pins are asynchronous to clk and are sampled here; the
  board resolves each cell pin from cellPinOut and cellPinOeN.
*/
// Our own choices: register access over AXI4-Lite and the address map.
// What this block does
// - Inputs reach plane true and inverted
// - Plane terms feed fixed OR per cell
// - True plus inverted connection yields zero
// - Term without connections yields one
// - Combinatorial: inverted OR of six, always driven
// - Bidirectional: inverted OR of seven, pin fed back
// - Bidirectional: own term enables the driver
// - Registered: flop of eight terms, Q fed back
// - Shared clock, one bank enable for registers
// - Polarity XOR: one inverts, zero passes
// - Identical cells, four selectable modes
// - Sync bit: all combinatorial, clock pins inputs
`timescale 1ns/1ps
module som_sop_slice
  import som_pkg::*;
#(
  parameter int NIN = SOM_NUM_IN, // Dedicated inputs
  parameter int NCELL = SOM_NUM_CELL // Output cells
) (
  input wire logic clk, // 10 MHz system clock
  input wire logic rst, // Synchronous reset, high
  input wire logic [NIN-1:0] inPin, // Dedicated input pins
  input wire logic clkPin, // Shared register clock pin
  input wire logic bankOeNPin, // Bank driver enable, low
  input wire logic [NCELL-1:0] cellPinIn, // Cell pin levels
  output logic [NCELL-1:0] cellPinOut, // Cell pin drive value
  output logic [NCELL-1:0] cellPinOeN, // Cell driver enable, low
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [SOM_ADDR_W-1:0] awaddr, // Write address
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte enables
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  output logic [1:0] bresp, // Write response
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  input wire logic [SOM_ADDR_W-1:0] araddr, // Read address
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp // Read response
);
  // Plane columns: true and inverted copy of each input, each cell
  // feedback, then the clock pin and the bank pin, in that order
  localparam int NPT = NCELL * SOM_PT_PER_CELL; // Terms in plane
  localparam int NCOL = 2 * (NIN + NCELL + 2); // Plane columns
  localparam int CKCOL = 2 * (NIN + NCELL); // Clock pin column

  // All state of the slice
  typedef struct packed {
    logic ctrlSync; // All-combinatorial arrangement
    logic ctrlArch; // Term-controlled enables allowed
    som_mode_t [NCELL-1:0] mode; // Per-cell structure
    logic [NCELL-1:0] pol; // Per-cell polarity
    logic [NPT-1:0][NCOL-1:0] ptMask; // One bit per connection
    logic [NCELL-1:0] q; // Cell flip-flops
    logic [NCELL-1:0] pinOut; // Registered pin value
    logic [NCELL-1:0] pinOeN; // Registered driver enable
    logic [NIN-1:0] in1; // Input sync stage one
    logic [NIN-1:0] in2; // Input sync stage two
    logic [NCELL-1:0] io1; // Cell pin sync stage one
    logic [NCELL-1:0] io2; // Cell pin sync stage two
    logic ck1; // Clock pin stage one
    logic ck2; // Clock pin stage two
    logic ckLast; // Clock pin edge history
    logic be1; // Bank enable stage one
    logic be2; // Bank enable stage two
    logic awHeld; // Write address captured
    logic [SOM_ADDR_W-1:0] awAddr; // Captured write address
    logic wHeld; // Write data captured
    logic [31:0] wData; // Captured write data
    logic [3:0] wStrb; // Captured byte enables
    logic awReady; // Address channel open
    logic wReady; // Data channel open
    logic bValid; // Write answer pending
    logic [1:0] bResp; // Write answer code
    logic arReady; // Read channel open
    logic rValid; // Read answer pending
    logic [31:0] rData; // Read answer data
    logic [1:0] rResp; // Read answer code
  } som_state_t;

  // One register holds everything, so reset and capture share one place
  som_state_t st; // Current state
  som_state_t next_st; // Next state

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] somMerge(input logic [31:0] oldW,
      input logic [31:0] newW, input logic [3:0] strb);
    logic [31:0] res;
    res = oldW;
    // Lanes with a clear strobe keep their old byte
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = newW[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Word index of a product-term mask, or out of range
  function automatic logic [SOM_ADDR_W-1:0] somPtIdx(input logic [SOM_ADDR_W-1:0] a);
    // Below the base the difference wraps high and fails the range test
    return (a - SOM_OFS_PT_BASE) >> 2;
  endfunction

  // Plane, cells, flip-flops and bus slave
  always_comb begin
    logic [NCOL-1:0] col; // Plane column values
    logic [NPT-1:0] pt; // Product term results
    logic [NCELL-1:0] fb; // Feedback per cell
    logic [NCELL-1:0] sum; // Value before inversion
    logic [NCELL-1:0] oe; // Driver enable, high
    logic [NCELL-1:0] regD; // Flip-flop data
    logic ckRise; // Clock pin rising
    logic [31:0] cur; // Old register word
    logic [31:0] wd; // Merged write word
    logic [31:0] rd; // Read word
    logic [SOM_ADDR_W-1:0] idx; // Term word index
    logic hit; // Address mapped
    int b; // First term of a cell
    // Defaults first, so no path leaves a temporary unassigned
    next_st = st;
    ckRise = 1'b0;
    col = '0;
    pt = '0;
    fb = '0;
    sum = '0;
    oe = '0;
    regD = '0;
    cur = '0;
    wd = '0;
    rd = '0;
    idx = '0;
    hit = 1'b0;
    b = 0;
    // Two-stage synchronisers on every pin
    next_st.in1 = inPin;
    next_st.in2 = st.in1;
    next_st.io1 = cellPinIn;
    next_st.io2 = st.io1;
    next_st.ck1 = clkPin;
    next_st.ck2 = st.ck1;
    next_st.ckLast = st.ck2;
    next_st.be1 = bankOeNPin;
    next_st.be2 = st.be1;
    // Edge taken on the synchronised copy; a clock pin pulse shorter
    // than one clock can be missed, a limit of sampling the pin
    ckRise = st.ck2 & ~st.ckLast;
    // Input buffers: true and complement
    for (int i = 0; i < NIN; i++) begin
      col[i] = st.in2[i];
      col[NIN+i] = ~st.in2[i];
    end
    // Feedback: Q when registered, else pin level
    for (int k = 0; k < NCELL; k++) begin
      if (st.mode[k] == SOM_MODE_REG && !st.ctrlSync) begin
        fb[k] = st.q[k];
      end else begin
        fb[k] = st.io2[k];
      end
      col[2*NIN+k] = fb[k];
      col[2*NIN+NCELL+k] = ~fb[k];
    end
    // Clock and bank pins join the plane only in sync mode
    // Outside sync mode they read zero, so a stray mask bit kills its term
    col[CKCOL] = st.ctrlSync & st.ck2;
    col[CKCOL+1] = st.ctrlSync & ~st.ck2;
    col[CKCOL+2] = st.ctrlSync & st.be2;
    col[CKCOL+3] = st.ctrlSync & ~st.be2;
    // AND plane: unconnected columns are ones, so empty term is one
    for (int t = 0; t < NPT; t++) begin
      // A set mask bit lets its column through; a clear bit reads one
      pt[t] = &(~st.ptMask[t] | col);
    end
    // Same cell logic for every pin
    for (int k = 0; k < NCELL; k++) begin
      b = k * SOM_PT_PER_CELL;
      // Full eight-term sum, used by registered and sync structures
      regD[k] = |pt[b +: SOM_PT_REG];
      unique case (st.mode[k])
        SOM_MODE_COMB: begin
          sum[k] = |pt[b +: SOM_PT_COMB];
          oe[k] = 1'b1;
        end
        SOM_MODE_IO: begin
          sum[k] = |pt[b+1 +: SOM_PT_IO];
          // First term of the cell gates the driver
          oe[k] = st.ctrlArch ? pt[b] : 1'b1;
        end
        SOM_MODE_REG: begin
          if (st.ctrlSync) begin
            sum[k] = regD[k];
            oe[k] = 1'b1;
          end else begin
            sum[k] = st.q[k];
            oe[k] = ~st.be2;
          end
        end
        SOM_MODE_INPUT: begin
          // Driver off; the pin still reaches the plane as feedback
          sum[k] = 1'b0;
          oe[k] = 1'b0;
        end
      endcase
      // Structure inverts; polarity XOR may undo it
      next_st.pinOut[k] = ~(sum[k] ^ st.pol[k]);
      // Enable stored active low to match the pin
      next_st.pinOeN[k] = ~oe[k];
      // Shared clock edge loads every registered cell
      if (ckRise && !st.ctrlSync && st.mode[k] == SOM_MODE_REG) begin
        next_st.q[k] = regD[k];
      end
    end
    // Write channels, taken in either order
    // Answer retired first, so a commit in the same cycle may reuse it
    if (st.bValid && bready) begin
      next_st.bValid = 1'b0;
    end
    if (awvalid && st.awReady) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = awaddr;
    end
    if (wvalid && st.wReady) begin
      next_st.wHeld = 1'b1;
      next_st.wData = wdata;
      next_st.wStrb = wstrb;
    end
    // Commit once both halves are held
    if (next_st.awHeld && next_st.wHeld && !next_st.bValid) begin
      idx = somPtIdx(next_st.awAddr);
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bValid = 1'b1;
      hit = 1'b1;
      // Strobe merge keeps unwritten lanes of the old word
      if (next_st.awAddr[7:2] == SOM_OFS_CTRL[7:2]) begin
        cur = '0;
        cur[SOM_CTRL_SYNC_BIT] = st.ctrlSync;
        cur[SOM_CTRL_ARCH_BIT] = st.ctrlArch;
        wd = somMerge(cur, next_st.wData, next_st.wStrb);
        next_st.ctrlSync = wd[SOM_CTRL_SYNC_BIT];
        next_st.ctrlArch = wd[SOM_CTRL_ARCH_BIT];
      end else if (next_st.awAddr[7:2] == SOM_OFS_CELLCFG[7:2]) begin
        cur = '0;
        for (int k = 0; k < NCELL; k++) begin
          cur[2*k +: 2] = st.mode[k];
          cur[SOM_CFG_POL_LSB+k] = st.pol[k];
        end
        wd = somMerge(cur, next_st.wData, next_st.wStrb);
        for (int k = 0; k < NCELL; k++) begin
          next_st.mode[k] = som_mode_t'(wd[2*k +: 2]);
          next_st.pol[k] = wd[SOM_CFG_POL_LSB+k];
        end
      end else if (next_st.awAddr >= SOM_OFS_PT_BASE && idx < NPT) begin
        cur = '0;
        cur[NCOL-1:0] = st.ptMask[idx];
        wd = somMerge(cur, next_st.wData, next_st.wStrb);
        next_st.ptMask[idx] = wd[NCOL-1:0];
      end else if (next_st.awAddr[7:2] != SOM_OFS_STATUS[7:2]) begin
        hit = 1'b0; // Unmapped, nothing stored
      end
      // Status writes keep hit set: answered OKAY, nothing stored
      next_st.bResp = hit ? SOM_RESP_OKAY : SOM_RESP_SLVERR;
    end
    // Read channel
    if (st.rValid && rready) begin
      next_st.rValid = 1'b0;
    end
    // Read word captured at acceptance and held until taken
    if (arvalid && st.arReady) begin
      idx = somPtIdx(araddr);
      hit = 1'b1;
      if (araddr[7:2] == SOM_OFS_CTRL[7:2]) begin
        rd[SOM_CTRL_SYNC_BIT] = st.ctrlSync;
        rd[SOM_CTRL_ARCH_BIT] = st.ctrlArch;
      end else if (araddr[7:2] == SOM_OFS_CELLCFG[7:2]) begin
        for (int k = 0; k < NCELL; k++) begin
          rd[2*k +: 2] = st.mode[k];
          rd[SOM_CFG_POL_LSB+k] = st.pol[k];
        end
      end else if (araddr[7:2] == SOM_OFS_STATUS[7:2]) begin
        rd[SOM_ST_PIN_LSB +: NCELL] = st.pinOut;
        rd[SOM_ST_Q_LSB +: NCELL] = st.q;
        rd[SOM_ST_OE_LSB +: NCELL] = ~st.pinOeN;
        rd[SOM_ST_IN_LSB +: NCELL] = st.io2;
      end else if (araddr >= SOM_OFS_PT_BASE && idx < NPT) begin
        rd[NCOL-1:0] = st.ptMask[idx];
      end else begin
        hit = 1'b0; // Unmapped reads as zero
      end
      next_st.rValid = 1'b1;
      next_st.rData = rd;
      next_st.rResp = hit ? SOM_RESP_OKAY : SOM_RESP_SLVERR;
    end
    // Readies from the coming state, so outputs stay flops
    // A held half or a pending answer closes its channel
    next_st.awReady = ~next_st.awHeld & ~next_st.bValid;
    next_st.wReady = ~next_st.wHeld & ~next_st.bValid;
    next_st.arReady = ~next_st.rValid;
    // Reset: erased plane has every connection, so terms read zero
    if (rst) begin
      next_st = '0;
      next_st.ctrlSync = SOM_RST_SYNC;
      next_st.ctrlArch = SOM_RST_ARCH;
      for (int k = 0; k < NCELL; k++) begin
        next_st.mode[k] = SOM_RST_MODE;
        next_st.pol[k] = SOM_RST_POL;
      end
      next_st.ptMask = '1;
      next_st.pinOeN = '1;
    end
  end

  // State register
  // Reset is folded into next_st, so one edge does all the work
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // Outputs straight from state flops
  assign cellPinOut = st.pinOut;
  assign cellPinOeN = st.pinOeN;
  assign awready = st.awReady;
  assign wready = st.wReady;
  assign bvalid = st.bValid;
  assign bresp = st.bResp;
  assign arready = st.arReady;
  assign rvalid = st.rValid;
  assign rdata = st.rData;
  assign rresp = st.rResp;
endmodule

// *** sim/som_sop_slice_asserts.sv ***
/*
  Checker for the sum-of-products slice: pin drivers by cell mode, bus handshakes.
  Assumes full-word register writes whose address and data are taken together.
*/
`timescale 1ns/1ps
module som_sop_slice_asserts
  import som_pkg::*;
#(
  parameter int NCELL = SOM_NUM_CELL // Output cells
) (
  input wire logic clk, // Clock
  input wire logic rst, // Reset, high
  input wire logic clkPin, // Register clock pin
  input wire logic [NCELL-1:0] cellPinOut, // Pin drive value
  input wire logic [NCELL-1:0] cellPinOeN, // Driver enable, low
  input wire logic awvalid, // Write address valid
  input wire logic awready, // Write address ready
  input wire logic [SOM_ADDR_W-1:0] awaddr, // Write address
  input wire logic wvalid, // Write data valid
  input wire logic wready, // Write data ready
  input wire logic [31:0] wdata, // Write data
  input wire logic bvalid, // Response valid
  input wire logic bready, // Response ready
  input wire logic [1:0] bresp, // Response code
  input wire logic arvalid, // Read address valid
  input wire logic arready, // Read address ready
  input wire logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic [31:0] rdata // Read data
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Shadow of the mode settings, snooped off the bus
  typedef struct packed {
    logic sync; // Combinatorial mode select
    logic arch; // Architecture control
    logic [2*NCELL-1:0] modes; // Cell modes
    logic [2:0] age; // Cycles since last write, saturating
  } som_shadow_t;
  som_shadow_t sh, next_sh;
  logic wrHit; // Write taken this edge
  logic [NCELL-1:0] inM, combM, ioM, regM; // Cells per mode
  assign wrHit = awvalid && awready && wvalid && wready;
  // Settle counter keeps checks off pipeline transients
  always_comb begin
    next_sh = sh;
    if (wrHit) begin
      next_sh.age = 3'h0;
      if (awaddr == SOM_OFS_CTRL) {next_sh.arch, next_sh.sync} = wdata[1:0];
      if (awaddr == SOM_OFS_CELLCFG) next_sh.modes = wdata[2*NCELL-1:0];
    end else if (sh.age != 3'h7) begin
      next_sh.age = sh.age + 3'h1;
    end
    for (int k = 0; k < NCELL; k++) begin
      inM[k] = sh.modes[2*k+:2] == SOM_MODE_INPUT;
      combM[k] = sh.modes[2*k+:2] == SOM_MODE_COMB;
      ioM[k] = sh.modes[2*k+:2] == SOM_MODE_IO;
      regM[k] = sh.modes[2*k+:2] == SOM_MODE_REG;
    end
  end
  // Shadow register
  always_ff @(posedge clk) begin
    if (rst) begin
      sh <= {1'h0, 1'h1, {NCELL{SOM_MODE_INPUT}}, 3'h0};
    end else begin
      sh <= next_sh;
    end
  end
  sequence s_quiet; (sh.age == 3'h7 && !sh.sync && !clkPin)[*6]; endsequence
  sequence s_wr; awvalid && awready && wvalid && wready; endsequence
  property p_in_float; sh.age == 3'h7 |-> &(cellPinOeN | ~inM); endproperty
  property p_comb_on; sh.age == 3'h7 |-> (cellPinOeN & combM) == '0; endproperty
  property p_bank; sh.age == 3'h7 && !sh.sync |->
    (cellPinOeN & regM) == '0 || (cellPinOeN & regM) == regM; endproperty
  property p_sync_on; sh.age == 3'h7 && sh.sync |-> (cellPinOeN & regM) == '0; endproperty
  property p_arch_io; sh.age == 3'h7 && !sh.arch |-> (cellPinOeN & ioM) == '0; endproperty
  property p_reg_hold; s_quiet |-> $stable(cellPinOut & regM); endproperty
  property p_bresp; s_wr |=> bvalid; endproperty
  property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  property p_read; arvalid && arready |=> rvalid ##0 !arready; endproperty
  a_in_float: assert property (p_in_float) else $error("input cell drives");
  a_comb_on: assert property (p_comb_on) else $error("comb cell floats");
  a_bank: assert property (p_bank) else $error("bank enables split");
  a_sync_on: assert property (p_sync_on) else $error("sync cell floats");
  a_arch_io: assert property (p_arch_io) else $error("io cell floats");
  a_reg_hold: assert property (p_reg_hold) else $error("reg moved unclocked");
  a_bresp: assert property (p_bresp) else $error("write response late");
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  a_read: assert property (p_read) else $error("read answer late");
endmodule
bind som_sop_slice som_sop_slice_asserts #(.NCELL(NCELL)) uChk (.clk, .rst, .clkPin,
  .cellPinOut, .cellPinOeN, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
  .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata);

// *** sim/som_board.sv ***
/*
  Board around the slice: resolves each cell pin from the slice and a board driver.
  Assumes the board driver only wins while the slice driver is off.
*/
`timescale 1ns/1ps
module som_board #(
  parameter int NCELL = 4 // Output cells
) (
  input wire logic [NCELL-1:0] cellPinOut, // Slice drive value
  input wire logic [NCELL-1:0] cellPinOeN, // Slice driver off when high
  input wire logic [NCELL-1:0] extLevel, // Board driver level
  output logic [NCELL-1:0] cellPinIn // Resolved pin level
);
  // Pin level per cell; no contention modelled
  always_comb begin
    for (int k = 0; k < NCELL; k++) begin
      cellPinIn[k] = cellPinOeN[k] ? extLevel[k] : cellPinOut[k];
    end
  end
endmodule

// *** sim/sop_output_macrocell_test.sv ***
/*
  Self-checking bench for the slice: register accesses, then each cell mode.
  Assumes the slice, its checker and the board model are compiled first.
*/
`timescale 1ns/1ps
module sop_output_macrocell_test
  import som_pkg::*;
  ;
  logic clk = 1'h0, rst = 1'h1, clkPin = 1'h0, bankOeNPin = 1'h0; // Clock, pins
  logic [3:0] inPin = 4'h0, extLevel = 4'h0, wstrb = 4'hF, cellPinIn, cellPinOut, cellPinOeN;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid; // Slave handshakes
  logic [7:0] awaddr = 8'h00, araddr = 8'h00; // Addresses
  logic [31:0] wdata = 32'h0, rdata, d; // Data, last read
  logic [1:0] bresp, rresp; // Responses
  int miscompares = 0, n_checks = 0;
  always #50 clk = ~clk;
  som_sop_slice uut (.clk, .rst, .inPin, .clkPin, .bankOeNPin, .cellPinIn, .cellPinOut,
    .cellPinOeN, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
  som_board board (.cellPinOut, .cellPinOeN, .extLevel, .cellPinIn);
  task finish_test;
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t word %h exp %h", $time, g, e);
    end
  endtask
  task chkBit(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  // Hung bus ends the run
  task tmo(input int n);
    if (n >= 200) begin
      miscompares++;
      $display("[ERR] %0t bus hang", $time);
      finish_test;
    end
  endtask
  // Pin path settles within four edges
  task wt;
    repeat (4) @(posedge clk);
  endtask
  // Address and data offered together, each released once taken
  task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    logic done;
    awaddr <= a; wdata <= v; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    n = 0;
    done = 1'h0;
    while (!done && n < 200) begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) begin
        done = 1'h1;
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, er});
      end
    end
    @(posedge clk); // Free edge so a next call never re-drives bready in one step
    tmo(n);
  endtask
  task rd(input logic [7:0] a, input logic [1:0] er);
    int n;
    logic done;
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    n = 0;
    done = 1'h0;
    while (!done && n < 200) begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        done = 1'h1;
        d = rdata;
        rready <= 1'h0;
        chk({30'h0, rresp}, {30'h0, er});
      end
    end
    @(posedge clk); // Free edge so a next call never re-drives rready in one step
    tmo(n);
  endtask
  task wc(input logic [7:0] a, input logic [31:0] v);
    wr(a, v, SOM_RESP_OKAY);
    wt;
  endtask
  task pt(input int t, input logic [19:0] m);
    wc(SOM_OFS_PT_BASE + 8'(4 * t), {12'h0, m});
  endtask
  task pulse;
    clkPin <= 1'h1;
    wt;
    clkPin <= 1'h0;
    wt;
  endtask
  // Main sequence: map, comb cell, io cell, reg cells, sync mode
  initial begin
    repeat (20) @(posedge clk);
    chk({28'h0, cellPinOeN}, 32'hF);
    rst <= 1'h0;
    @(posedge clk);
    rd(SOM_OFS_CTRL, SOM_RESP_OKAY);
    chk(d, 32'h2);
    rd(SOM_OFS_CELLCFG, SOM_RESP_OKAY);
    chk(d, 32'hAA);
    rd(8'h0C, SOM_RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h0C, 32'h1, SOM_RESP_SLVERR);
    wr(SOM_OFS_STATUS, 32'h1, SOM_RESP_OKAY);
    wc(SOM_OFS_CELLCFG, 32'h100F4);
    chkBit(cellPinOut[0], 1'h0);
    pt(0, 20'h0);
    chkBit(cellPinOut[0], 1'h1);
    wc(SOM_OFS_CELLCFG, 32'hF4);
    chkBit(cellPinOut[0], 1'h0);
    wc(SOM_OFS_CELLCFG, 32'h100F4);
    pt(0, 20'h1);
    chkBit(cellPinOut[0], 1'h0);
    inPin[0] <= 1'h1;
    wt;
    chkBit(cellPinOut[0], 1'h1);
    pt(0, 20'h10);
    chkBit(cellPinOut[0], 1'h0);
    pt(0, 20'h11);
    chkBit(cellPinOut[0], 1'h0);
    inPin[0] <= 1'h0;
    wt;
    chkBit(cellPinOut[0], 1'h0);
    pt(0, 20'hFFFFF);
    pt(6, 20'h0);
    chkBit(cellPinOut[0], 1'h0);
    pt(5, 20'h0);
    chkBit(cellPinOut[0], 1'h1);
    pt(8, 20'h2);
    chkBit(cellPinOeN[1], 1'h1);
    pt(9, 20'h200);
    extLevel[1] <= 1'h1;
    wt;
    chkBit(cellPinOut[1], 1'h0);
    rd(SOM_OFS_STATUS, SOM_RESP_OKAY);
    chkBit(d[25], 1'h1);
    extLevel[1] <= 1'h0;
    wt;
    chkBit(cellPinOut[1], 1'h1);
    pt(9, 20'hFFFFF);
    inPin[1] <= 1'h1;
    wt;
    chkBit(cellPinOeN[1], 1'h0);
    pt(15, 20'h0);
    chkBit(cellPinOut[1], 1'h0);
    inPin[1] <= 1'h0;
    wc(SOM_OFS_CTRL, 32'h0);
    chkBit(cellPinOeN[1], 1'h0);
    wt;
    wc(SOM_OFS_CTRL, 32'h2);
    pt(16, 20'h4000);
    chkBit(cellPinOut[2], 1'h1);
    pulse;
    chkBit(cellPinOut[2], 1'h0);
    rd(SOM_OFS_STATUS, SOM_RESP_OKAY);
    chkBit(d[10], 1'h1);
    pulse;
    chkBit(cellPinOut[2], 1'h1);
    pt(23, 20'h0);
    pulse;
    pulse;
    chkBit(cellPinOut[2], 1'h0);
    bankOeNPin <= 1'h1;
    wt;
    chk({30'h0, cellPinOeN[3:2]}, 32'h3);
    bankOeNPin <= 1'h0;
    wt;
    chk({30'h0, cellPinOeN[3:2]}, 32'h0);
    bankOeNPin <= 1'h1;
    pt(16, 20'hFFFFF);
    pt(24, 20'h10000);
    wc(SOM_OFS_CTRL, 32'h3);
    chk({30'h0, cellPinOeN[3:2]}, 32'h0);
    clkPin <= 1'h1;
    wt;
    chkBit(cellPinOut[3], 1'h0);
    clkPin <= 1'h0;
    wt;
    chkBit(cellPinOut[3], 1'h1);
    finish_test;
  end
endmodule
